// File: hw/nv_spi_pkg.sv
package nv_spi_pkg;

  // ==========================================================
  // Array geometry
  localparam int ADDR_W = 9;            // Byte address width
  localparam int DATA_W = 8;            // Byte width
  localparam int MEM_DEPTH = 512;       // Storage locations
  localparam int FIFO_DEPTH = 32;       // Write buffer words
  localparam int FIFO_W = ADDR_W + DATA_W;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_ARM = 8'h06;      // arm_write_cmd
  localparam logic [7:0] OP_DISARM = 8'h04;   // disarm_write_cmd
  localparam logic [7:0] OP_STAT_RD = 8'h05;  // status_read_cmd
  localparam logic [7:0] OP_STAT_WR = 8'h01;  // status_write_cmd
  localparam logic [2:0] OP_RD_LOW = 3'h3;    // Low bits of read
  localparam logic [2:0] OP_WR_LOW = 3'h2;    // Low bits of write
  localparam int OP_ADDR_POS = 3;             // Address bit 8 in opcode

  // ==========================================================
  // Status layout and reset values
  localparam int STAT_WEL_POS = 1;
  localparam int STAT_BP_POS = 2;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic WEL_RST = 1'b0;

  // ==========================================================
  // Protected range starts per block code
  localparam logic [8:0] PROT_QUARTER = 9'h180;
  localparam logic [8:0] PROT_HALF = 9'h100;
  localparam logic [8:0] PROT_ALL = 9'h000;

  // ==========================================================
  // Pin sampling: {protectInN, pauseN, serialIn, serialClk, selectN}
  localparam logic [4:0] PIN_IDLE = 5'h19;
  localparam int PIN_SEL = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_PAUSE = 3;
  localparam int PIN_PROT = 4;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCK_MIN_PERIOD_NS = 100;  // 10 MHz ceiling
  localparam int SCK_MIN_PERIOD_CYC = SCK_MIN_PERIOD_NS / CLK_PERIOD_NS;

  // Port sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_WR, ST_RD, ST_SRD, ST_SWR, ST_IGN
  } port_state_t;

endpackage

// File: hw/sync_fifo.sv
module sync_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  // ==========================================================
  // Parameter check
  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
      $error("sync_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] store [DEPTH];  // Word storage
  logic [PW:0] wrPtr_q;             // Fill pointer with wrap bit
  logic [PW:0] rdPtr_q;             // Drain pointer with wrap bit
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  // Full when pointers differ only in wrap bit
  assign inReady = !((wrPtr_q[PW] != rdPtr_q[PW]) && (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]));
  assign outValid = (wrPtr_q != rdPtr_q);
  assign outData = store[rdPtr_q[PW-1:0]];

  // ==========================================================
  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wrPtr_q[PW-1:0]] <= inData;
    end
  end

  // Pointer update
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + (PW+1)'(push);
      rdPtr_q <= rdPtr_q + (PW+1)'(pop);
    end
  end

endmodule

// File: hw/nv_spi_port.sv
// Operation
// [R1] Select high: standby, inputs ignored, output released
// [R2] Host gives select falling edge per opcode
// [R3] Sample on clock rise, shift out on fall
// [R4] Static logic, clock 0 to 10 MHz
// [R5] Pause low freezes clock and select handling
// [R6] Host changes pause only while clock low
// [R7] Protect pin low blocks all writes
// [R8] Output driven only for read data
// [R9] 512 bytes, 9-bit byte address
// [R10] Address bit 8 rides in opcode
// [R11] Byte committed right after eighth bit
// [R12] Never busy, no polling needed
// [R13] Power-on reset sets defined state
// [R14] Host keeps power while selected
// [R15] Output released so data pins may join
// [R16] Modes 0 and 3, rising-edge sampling
// [R17] Six opcodes decoded
// [R18] Bytes shifted most significant bit first
// [R19] Write arm flag set, cleared by writes
// [R20] One opcode per select assertion
// [R21] Burst address increments and wraps
module nv_spi_port #(
  parameter int FIFO_DEPTH = nv_spi_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial pins from host
  input wire logic deviceSelectN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic pauseN,
  input wire logic protectInN,
  // Serial data out, tri-state split
  output logic serialOut,
  output logic serialOutOe
);

  // ==========================================================
  // Parameter check
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("nv_spi_port: FIFO_DEPTH too small");
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic [4:0] syncA_q;   // First stage, read by second only
  logic [4:0] syncB_q;   // Second stage, safe to use
  logic sckPrev_q;       // Clock history for edge find
  logic selEffN_q;       // Select as seen past pause

  // Two flops per pin, reset to idle levels
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= nv_spi_pkg::PIN_IDLE;
      syncB_q <= nv_spi_pkg::PIN_IDLE;
    end else begin
      syncA_q <= {protectInN, pauseN, serialIn, serialClk, deviceSelectN};
      syncB_q <= syncA_q;
    end
  end

  wire pauseOk = syncB_q[nv_spi_pkg::PIN_PAUSE];   // Not paused
  wire protOk = syncB_q[nv_spi_pkg::PIN_PROT];     // Writes allowed by pin
  wire sckS = syncB_q[nv_spi_pkg::PIN_SCK];
  wire siS = syncB_q[nv_spi_pkg::PIN_SI];
  wire selS = syncB_q[nv_spi_pkg::PIN_SEL];

  // Select held while paused; clock history always tracked
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      selEffN_q <= 1'b1;
      sckPrev_q <= 1'b0;
    end else begin
      selEffN_q <= pauseOk ? selS : selEffN_q; // R5
      sckPrev_q <= sckS; // R4
    end
  end

  // ==========================================================
  // Event decode
  wire active = !selEffN_q && pauseOk;                   // R1 R5
  wire frameStart = pauseOk && selEffN_q && !selS;       // R2
  wire frameEnd = pauseOk && !selEffN_q && selS;
  wire sckRise = active && sckS && !sckPrev_q;           // R3 R16
  wire sckFall = active && !sckS && sckPrev_q;           // R3

  // ==========================================================
  // Sequencer state
  nv_spi_pkg::port_state_t state_q;  // Current phase
  nv_spi_pkg::port_state_t state_d;
  logic [2:0] bitCnt_q;              // Bit within byte
  logic [6:0] shift_q;               // Input shift register
  logic [8:0] addr_q;                // Byte address
  logic addrHi_q;                    // Address bit 8 from opcode
  logic isRead_q;                    // Memory op is a read
  logic wel_q;                       // write_arm_flag
  logic [1:0] bp_q;                  // Block protect code
  logic wrDone_q;                    // A write finished this frame
  logic started_q;                   // Output phase begun
  logic [7:0] rdByte_q;              // Next byte to send
  logic [7:0] outSh_q;               // Output shift register
  logic soQ;                         // Output data flop
  logic soOeQ;                       // Output enable flop

  wire [7:0] byteIn = {shift_q, siS};                         // R18
  wire byteDone = sckRise && (bitCnt_q == 3'h7);
  wire [7:0] statusByte = {4'h0, bp_q, wel_q, 1'b0};
  wire opIsRd = (byteIn[7:4] == 4'h0) && (byteIn[2:0] == nv_spi_pkg::OP_RD_LOW);
  wire opIsWr = (byteIn[7:4] == 4'h0) && (byteIn[2:0] == nv_spi_pkg::OP_WR_LOW);
  wire inOpc = (state_q == nv_spi_pkg::ST_OPC);
  wire inRd = (state_q == nv_spi_pkg::ST_RD);
  wire inWr = (state_q == nv_spi_pkg::ST_WR);
  wire inSrd = (state_q == nv_spi_pkg::ST_SRD);
  wire inSwr = (state_q == nv_spi_pkg::ST_SWR);
  wire inAddr = (state_q == nv_spi_pkg::ST_ADDR);
  wire sending = inRd || inSrd;

  // Protected region lookup
  wire [8:0] protStart = (bp_q == 2'h1) ? nv_spi_pkg::PROT_QUARTER :
                         (bp_q == 2'h2) ? nv_spi_pkg::PROT_HALF : nv_spi_pkg::PROT_ALL;
  wire protHit = (bp_q != nv_spi_pkg::BP_RST) && (addr_q >= protStart);
  wire wrOk = wel_q && protOk && !protHit;                    // R7 R19
  wire statWrOk = wel_q && protOk;                            // R7

  // Next phase
  always_comb begin
    state_d = state_q;
    case (state_q)
      nv_spi_pkg::ST_IDLE: state_d = nv_spi_pkg::ST_IDLE;
      nv_spi_pkg::ST_OPC: begin
        if (byteIn == nv_spi_pkg::OP_STAT_RD) begin
          state_d = nv_spi_pkg::ST_SRD;
        end else if (byteIn == nv_spi_pkg::OP_STAT_WR) begin
          state_d = nv_spi_pkg::ST_SWR;
        end else if (opIsRd || opIsWr) begin
          state_d = nv_spi_pkg::ST_ADDR;
        end else begin
          state_d = nv_spi_pkg::ST_IGN; // R20
        end
      end
      nv_spi_pkg::ST_ADDR: state_d = isRead_q ? nv_spi_pkg::ST_RD : nv_spi_pkg::ST_WR;
      nv_spi_pkg::ST_SWR: state_d = nv_spi_pkg::ST_IGN;
      default: state_d = state_q;
    endcase
  end

  // Phase register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= nv_spi_pkg::ST_IDLE; // R13
    end else if (frameStart) begin
      state_q <= nv_spi_pkg::ST_OPC;
    end else if (frameEnd) begin
      state_q <= nv_spi_pkg::ST_IDLE; // R1
    end else if (byteDone) begin
      state_q <= state_d; // R17
    end
  end

  // Bit count and input shift on rising edges only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_q <= 3'h0;
      shift_q <= 7'h00;
    end else if (frameStart) begin
      bitCnt_q <= 3'h0;
    end else if (sckRise) begin
      bitCnt_q <= bitCnt_q + 3'h1; // R3
      shift_q <= byteIn[6:0];      // R18
    end
  end

  // Address capture and burst increment
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 9'h000;
      addrHi_q <= 1'b0;
      isRead_q <= 1'b0;
    end else if (byteDone && inOpc) begin
      addrHi_q <= byteIn[nv_spi_pkg::OP_ADDR_POS]; // R10
      isRead_q <= opIsRd;
    end else if (byteDone && inAddr) begin
      addr_q <= {addrHi_q, byteIn}; // R10 R9
    end else if (byteDone && (inRd || inWr)) begin
      addr_q <= addr_q + 9'h001; // R21
    end
  end

  // Write arm flag and block protect bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= nv_spi_pkg::WEL_RST; // R13 R19
      bp_q <= nv_spi_pkg::BP_RST;
    end else if (frameEnd && wrDone_q) begin
      wel_q <= 1'b0; // R19
    end else if (byteDone && inOpc && byteIn == nv_spi_pkg::OP_ARM) begin
      wel_q <= 1'b1; // R17 R19
    end else if (byteDone && inOpc && byteIn == nv_spi_pkg::OP_DISARM) begin
      wel_q <= 1'b0; // R19
    end else if (byteDone && inSwr && statWrOk) begin
      bp_q <= byteIn[nv_spi_pkg::STAT_BP_POS +: 2]; // R7
    end
  end

  // Marks a completed write for the frame end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrDone_q <= 1'b0;
    end else if (frameStart) begin
      wrDone_q <= 1'b0;
    end else if (byteDone && (inWr || inSwr)) begin
      wrDone_q <= 1'b1; // R19
    end
  end

  // ==========================================================
  // Write buffer toward the array
  logic wrPend_q;                  // Byte waiting for buffer space
  logic [16:0] wrWord_q;           // Address and data of that byte
  logic fifoReady;
  logic drainValid;
  logic [16:0] drainWord;
  logic rdReq_q;                   // Array read request
  wire memWe = drainValid && !rdReq_q;  // Reads take priority

  // Commit holds until the buffer accepts it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrWord_q <= 17'h00000;
    end else if (byteDone && inWr && wrOk) begin
      wrPend_q <= 1'b1; // R11
      wrWord_q <= {addr_q, byteIn};
    end else if (fifoReady) begin
      wrPend_q <= 1'b0;
    end
  end

  sync_fifo #(
    .WIDTH(nv_spi_pkg::FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) wrBuf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(wrPend_q),
    .inReady(fifoReady),
    .inData(wrWord_q),
    .outValid(drainValid),
    .outReady(!rdReq_q),
    .outData(drainWord)
  );

  // ==========================================================
  // Storage array
  logic [7:0] mem [nv_spi_pkg::MEM_DEPTH];  // R9
  logic [7:0] memRdata_q;                   // Registered read data
  logic rdLoad_q;                           // Read data valid

  // Array write from the buffer
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      mem[drainWord[16:8]] <= drainWord[7:0]; // R11 R12
    end
  end

  // Read request at end of address and each read byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdReq_q <= 1'b0;
      rdLoad_q <= 1'b0;
      memRdata_q <= 8'h00;
    end else begin
      rdReq_q <= byteDone && ((inAddr && isRead_q) || inRd);
      rdLoad_q <= rdReq_q;
      memRdata_q <= rdReq_q ? mem[addr_q] : memRdata_q;
    end
  end

  // Next outgoing byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdByte_q <= 8'h00;
    end else if (rdLoad_q) begin
      rdByte_q <= memRdata_q;
    end else if (byteDone && (inSrd || (inOpc && byteIn == nv_spi_pkg::OP_STAT_RD))) begin
      rdByte_q <= statusByte;
    end
  end

  // ==========================================================
  // Serial output, changed on falling edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soQ <= 1'b0;
      outSh_q <= 8'h00;
      started_q <= 1'b0;
    end else if (frameStart) begin
      started_q <= 1'b0;
    end else if (sckFall && sending) begin
      started_q <= 1'b1;
      soQ <= (bitCnt_q == 3'h0) ? rdByte_q[7] : outSh_q[7]; // R3 R18
      outSh_q <= (bitCnt_q == 3'h0) ? {rdByte_q[6:0], 1'b0} : {outSh_q[6:0], 1'b0};
    end
  end

  // Drive only while returning data and not paused
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soOeQ <= 1'b0;
    end else begin
      soOeQ <= active && sending && (started_q || (sckFall && sending)); // R8 R15 R1
    end
  end

  assign serialOut = soQ;
  assign serialOutOe = soOeQ;

  // ==========================================================
  // Checks
  a_select_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    (selS && pauseOk) [*2] |=> !serialOutOe) else $error("output driven while deselected");
  a_pause_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    !pauseOk |=> !serialOutOe) else $error("output driven while paused");
  a_drive_only_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    serialOutOe |-> $past(sending)) else $error("output driven outside read");
  a_protect_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    $rose(wrPend_q) |-> $past(protOk) && $past(wel_q)) else $error("write while blocked");
  a_commit_prompt: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    (byteDone && inWr && wrOk) |-> ##[2:40] memWe) else $error("byte not committed");
  a_arm_sets: assert property (@(posedge clk_sys) disable iff (!rst_n) // R19
    (byteDone && inOpc && byteIn == nv_spi_pkg::OP_ARM) |=> wel_q) else $error("arm lost");
  a_disarm_clears: assert property (@(posedge clk_sys) disable iff (!rst_n) // R19
    (byteDone && inOpc && byteIn == nv_spi_pkg::OP_DISARM) |=> !wel_q)
    else $error("disarm lost");
  a_write_disarms: assert property (@(posedge clk_sys) disable iff (!rst_n) // R19
    (frameEnd && wrDone_q) |=> !wel_q) else $error("arm kept after write");
  a_addr_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n) // R21
    (byteDone && (inRd || inWr)) |=> addr_q == $past(addr_q) + 9'h001)
    else $error("address not advanced");
  a_addr_msb: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    (byteDone && inAddr) |=> addr_q == {$past(addrHi_q), $past(byteIn)})
    else $error("address bit 8 wrong");
  a_rise_only: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    (!sckRise && !frameStart) |=> bitCnt_q == $past(bitCnt_q)) else $error("bit off edge");
  a_msb_first: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
    (sckFall && sending && bitCnt_q == 3'h0) |=> soQ == $past(rdByte_q[7]))
    else $error("first bit not msb");

  c_mem_read: cover property (@(posedge clk_sys) disable iff (!rst_n) rdLoad_q && inRd);
  c_mem_write: cover property (@(posedge clk_sys) disable iff (!rst_n) memWe);
  c_status_read: cover property (@(posedge clk_sys) disable iff (!rst_n) serialOutOe && inSrd);
  c_pause: cover property (@(posedge clk_sys) disable iff (!rst_n) !pauseOk && sending);

endmodule

// File: test/spi_host_model.sv
// ==========================================================
// Host serial master driving the port's pins
module spi_host_model (
  // Clock
  input wire logic clk_sys,
  // Pins towards the device
  output logic deviceSelectN,
  output logic serialClk,
  output logic serialIn,
  output logic pauseN,
  output logic protectInN,
  // Device data output, tri-state split
  input wire logic serialOut,
  input wire logic serialOutOe,
  // Captured read bytes
  output logic rxValid,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF_CYC = 10; // Half of the 80 ns link period
  logic idleHigh = 1'b0; // Clock idles high when set
  logic lastSo = 1'b0; // Last level the device drove
  logic soWire; // Resolved data line
  int pauseBit = -1; // Bit at which a pause is inserted

  // Released line shows the inverse of the last driven level
  assign soWire = serialOutOe ? serialOut : ~lastSo;
  // Track the last driven level
  always @(posedge clk_sys) begin
    if (serialOutOe) begin
      lastSo <= serialOut;
    end
  end

  // Idle pin levels
  initial begin
    deviceSelectN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
    pauseN = 1'b1;
    protectInN = 1'b1;
    rxValid = 1'b0;
    rxByte = 8'h00;
  end

  // Pins change only on the falling system clock edge
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Fresh select fall for every opcode
  task automatic begin_frame();
    serialClk = idleHigh;
    wait_cyc(4);
    deviceSelectN = 1'b0;
    wait_cyc(HALF_CYC);
  endtask

  // Pause with clock low, clock pulses meanwhile must be ignored
  task automatic hold_pause();
    pauseN = 1'b0;
    wait_cyc(6);
    repeat (2) begin
      serialClk = 1'b1;
      wait_cyc(HALF_CYC);
      serialClk = 1'b0;
      wait_cyc(HALF_CYC);
    end
    pauseN = 1'b1;
    wait_cyc(HALF_CYC);
  endtask

  // One byte each way, data set while clock low, read on the rise
  task automatic xbyte(input logic [7:0] tx, input bit capture);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      serialClk = 1'b0;
      serialIn = tx[i];
      wait_cyc(HALF_CYC);
      if (i == pauseBit) begin
        hold_pause();
      end
      rx[i] = soWire;
      serialClk = 1'b1;
      wait_cyc(HALF_CYC);
    end
    if (capture) begin
      rxByte = rx;
      rxValid = 1'b1;
      wait_cyc(1);
      rxValid = 1'b0;
    end
  endtask

  // Clock back to idle, then raise select before the next opcode
  task automatic end_frame();
    wait_cyc(HALF_CYC);
    serialClk = idleHigh;
    wait_cyc(HALF_CYC);
    deviceSelectN = 1'b1;
    wait_cyc(4);
  endtask
endmodule

// File: test/serial_nv_memory_spi_port_tb.sv
module serial_nv_memory_spi_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got %h expected %h", $time, (got), (exp)); end end

  // ==========================================================
  // Signals
  logic clk_sys;
  logic rst_n;
  logic deviceSelectN, serialClk, serialIn, pauseN, protectInN;
  logic serialOut, serialOutOe;
  logic rxValid;
  logic [7:0] rxByte;
  int failures = 0;
  int n_checks = 0;
  int seed = 32'h4B21BD31; // Fixed seed for data bytes
  int relCnt = 0; // Cycles since select high or pause low
  logic [7:0] shadow [512]; // Expected array contents
  logic [7:0] expQ [$]; // Expected read bytes
  logic [8:0] pStart [3] = '{9'h180, 9'h100, 9'h000}; // Protected range starts

  // ==========================================================
  // Clock, design and host
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  nv_spi_port #(.FIFO_DEPTH(nv_spi_pkg::FIFO_DEPTH)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .deviceSelectN(deviceSelectN),
    .serialClk(serialClk), .serialIn(serialIn), .pauseN(pauseN),
    .protectInN(protectInN), .serialOut(serialOut), .serialOutOe(serialOutOe));

  spi_host_model host (
    .clk_sys(clk_sys), .deviceSelectN(deviceSelectN), .serialClk(serialClk),
    .serialIn(serialIn), .pauseN(pauseN), .protectInN(protectInN),
    .serialOut(serialOut), .serialOutOe(serialOutOe), .rxValid(rxValid),
    .rxByte(rxByte));

  // ==========================================================
  // Result watcher: oldest note against each captured byte
  always @(posedge clk_sys) begin
    if (rxValid === 1'b1) begin
      if (expQ.size() == 0) begin
        failures++;
        $display("MISMATCH t=%0t unexpected read byte", $time);
      end else `CHK(rxByte, expQ.pop_front())
    end
    relCnt = (deviceSelectN === 1'b1 || pauseN === 1'b0) ? relCnt + 1 : 0;
    if (relCnt > 5) `CHK(serialOutOe, 1'b0)
  end

  // ==========================================================
  // Frame tasks
  task automatic op1(input logic [7:0] op);
    host.begin_frame();
    host.xbyte(op, 1'b0);
    host.end_frame();
  endtask

  task automatic stat_rd(input logic [7:0] exp);
    host.begin_frame();
    host.xbyte(nv_spi_pkg::OP_STAT_RD, 1'b0);
    expQ.push_back(exp);
    host.xbyte(8'h00, 1'b1);
    host.end_frame();
  endtask

  task automatic stat_wr(input logic [7:0] v);
    op1(nv_spi_pkg::OP_ARM);
    host.begin_frame();
    host.xbyte(nv_spi_pkg::OP_STAT_WR, 1'b0);
    host.xbyte(v, 1'b0);
    host.end_frame();
  endtask

  // Burst write with random data, shadow kept only when allowed
  task automatic mem_wr(input logic [8:0] a, input int n, input bit arm, input bit ok);
    logic [8:0] ad;
    logic [7:0] d;
    ad = a;
    if (arm) op1(nv_spi_pkg::OP_ARM);
    host.begin_frame();
    host.xbyte({4'h0, a[8], nv_spi_pkg::OP_WR_LOW}, 1'b0);
    host.xbyte(a[7:0], 1'b0);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      if (ok) shadow[ad] = d;
      host.xbyte(d, 1'b0);
      ad++;
    end
    host.end_frame();
  endtask

  task automatic mem_rd(input logic [8:0] a, input int n);
    logic [8:0] ad;
    ad = a;
    host.begin_frame();
    host.xbyte({4'h0, a[8], nv_spi_pkg::OP_RD_LOW}, 1'b0);
    host.xbyte(a[7:0], 1'b0);
    for (int k = 0; k < n; k++) begin
      expQ.push_back(shadow[ad]);
      host.xbyte(8'h00, 1'b1);
      ad++;
    end
    host.end_frame();
  endtask

  task automatic reset_pulse();
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic final_report();
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    stat_rd(8'h00);
    $display("Test reset state done");
    // Arm, second opcode in one frame, unknown opcode, disarm
    op1(nv_spi_pkg::OP_ARM);
    stat_rd(8'h02);
    host.begin_frame();
    host.xbyte(nv_spi_pkg::OP_ARM, 1'b0);
    host.xbyte(nv_spi_pkg::OP_DISARM, 1'b0);
    host.end_frame();
    op1(8'hFF);
    stat_rd(8'h02);
    op1(nv_spi_pkg::OP_DISARM);
    stat_rd(8'h00);
    $display("Test arm flag done");
    // Wrapping burst with a pause in every byte, then unarmed write
    host.pauseBit = 4;
    mem_wr(9'h1FE, 4, 1'b1, 1'b1);
    host.pauseBit = -1;
    stat_rd(8'h00);
    mem_wr(9'h17F, 2, 1'b1, 1'b1);
    mem_wr(9'h0FF, 2, 1'b1, 1'b1);
    mem_wr(9'h1FF, 1, 1'b0, 1'b0);
    mem_rd(9'h1FE, 4);
    $display("Test burst done");
    // Protect pin low blocks array and status writes
    @(negedge clk_sys);
    protectInN = 1'b0;
    mem_wr(9'h000, 1, 1'b1, 1'b0);
    stat_wr(8'h0C);
    @(negedge clk_sys);
    protectInN = 1'b1;
    op1(nv_spi_pkg::OP_DISARM);
    stat_rd(8'h00);
    mem_rd(9'h000, 1);
    $display("Test protect pin done");
    // Block codes in mode 3, edge of each range
    host.idleHigh = 1'b1;
    for (int c = 1; c <= 3; c++) begin
      stat_wr({4'h0, 2'(c), 2'h0});
      stat_rd({4'h0, 2'(c), 2'h0});
      mem_wr(pStart[c-1], 1, 1'b1, 1'b0);
      mem_wr(pStart[c-1] - 9'h001, 1, 1'b1, c != 3);
      mem_rd(pStart[c-1] - 9'h001, 2);
    end
    stat_wr(8'hF3);
    stat_rd(8'h00);
    host.idleHigh = 1'b0;
    $display("Test block protect done");
    // Reset in mid-run clears the flag and block bits
    stat_wr(8'h08);
    op1(nv_spi_pkg::OP_ARM);
    reset_pulse();
    stat_rd(8'h00);
    $display("Test second reset done");
    `CHK(expQ.size() == 0, 1'b1)
    final_report();
  end

  // Watchdog well beyond the expected run time
  initial begin
    #400000;
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
endmodule
